// >>> inc/flash_seq_pkg.sv
// constants and carrier types for the flash write and security sequencer
package flash_seq_pkg;
   // address width and page size
   localparam int ADDR_W   = 16;
   localparam int PAGE_LSB = 10;                  // 1024-byte pages
   localparam int PAGE_W   = ADDR_W - PAGE_LSB;
   // unlock key codes, written in this order
   localparam logic [7:0] KEY_FIRST_CODE  = 8'hA5;
   localparam logic [7:0] KEY_SECOND_CODE = 8'hF1;
   // memory map of the store
   localparam logic [15:0] RESERVED_BASE  = 16'h7C00;
   localparam logic [15:0] LOCK_BYTE_ADDR = 16'h7BFF;
   localparam logic [PAGE_W-1:0] LOCK_PAGE = LOCK_BYTE_ADDR[ADDR_W-1:PAGE_LSB];
   localparam logic [7:0] NO_PAGES_LOCKED = 8'h00;
   localparam logic [1:0] BLOCK_LAST_IDX  = 2'h3;
   localparam logic [3:0] MASK_ONE_BYTE   = 4'h1;
   localparam logic [3:0] MASK_ALL_BYTES  = 4'hF;
   // register word offsets on the bus
   localparam logic [2:0] REG_STORE_CTRL = 3'h0;
   localparam logic [2:0] REG_CACHE_CTRL = 3'h1;
   localparam logic [2:0] REG_KEY        = 3'h2;
   localparam logic [2:0] REG_STATUS     = 3'h3;
   localparam logic [2:0] REG_SUPPLY     = 3'h4;
   // field positions
   localparam int BIT_WRITE_EN  = 0;
   localparam int BIT_ERASE_EN  = 1;
   localparam int BIT_BLOCK_SEL = 0;
   localparam int BIT_MON_EN    = 0;
   localparam int BIT_MON_RST   = 1;
   localparam int ST_BUSY       = 0;
   localparam int ST_FLASH_ERR  = 1;
   localparam int ST_ANY_LOCK   = 2;
   localparam int ST_PAGES_LSB  = 8;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // unlock sequence states
   typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_DEAD} key_state_type;
   // kinds of store access
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_FULL_ERASE} op_kind_type;

   // request to the flash array
   typedef struct packed {
      logic              start;
      op_kind_type       kind;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic [3:0]        mask;
   } flash_req_type;

   // request from the debug port
   typedef struct packed {
      logic              valid;
      op_kind_type       kind;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } dbg_req_type;

   // whole state of the sequencer
   typedef struct packed {
      key_state_type     key;
      logic              write_en;
      logic              erase_en;
      logic              block_sel;
      logic              mon_en;
      logic              mon_rst;
      logic              captured;
      logic [7:0]        pages;
      logic              flash_err;
      logic [1:0]        blk_next;
      logic [ADDR_W-1:0] blk_addr;
      logic [31:0]       blk_data;
      logic              busy;
      flash_req_type     flash;
      logic              external_data_ram_wr;
      logic              external_data_ram_rd;
      logic [ADDR_W-1:0] external_data_ram_addr;
      logic [7:0]        external_data_ram_wdata;
      logic              code_grant;
      logic              err_reset;
      logic              dbg_ack;
      logic              dbg_refused;
      logic              waitreq;
      logic [31:0]       readdata;
   } state_type;
endpackage

// >>> rtl/flash_write_security_ctrl.sv
// flash write sequencer with key unlock and page lock security
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - block programs only after byte ending 11b
// - code blocks are four aligned bytes
// - write enable steers move-writes to flash
// - move-reads always go to data RAM
// - modify needs write enable, erase needs both
// - inverse lock byte counts locked pages
// - lock byte page locked when any bit zero
// - locked access: firmware-locked ok, debug refused
// - other unlocked pages open to everyone
// - lock page erase: firmware faults, debug conditional
// - changing lock byte refused or faults once any page is locked
// - reserved area refused or faults
// - error reset leaves flash error flag set
// - refused debug operations never reset device
// - debug full erase clears everything
// - new lock byte acts after next reset
// - keys re-arm per operation, errors kill writes
// - modify without supply monitor faults
// - busy flag and fetch stall during operation
// - byte mode programs each move-write at once
module flash_write_security_ctrl
   import flash_seq_pkg::*;
(
   input  wire logic                        CORE_CLK,
   input  wire logic                        NRST,
   input  wire logic [2:0]                  AVS_ADDRESS,
   input  wire logic                        AVS_READ,
   input  wire logic                        AVS_WRITE,
   input  wire logic [31:0]                 AVS_WRITEDATA,
   input  wire logic [3:0]                  AVS_BYTEENABLE,
   output logic [31:0]                      AVS_READDATA,
   output logic                             AVS_WAITREQUEST,
   input  wire logic                        MOVE_WR,
   input  wire logic                        MOVE_RD,
   input  wire logic [flash_seq_pkg::ADDR_W-1:0] MOVE_ADDR,
   input  wire logic [7:0]                  MOVE_DATA,
   input  wire logic [flash_seq_pkg::ADDR_W-1:0] EXEC_ADDR,
   input  wire logic                        CODE_RD,
   input  wire logic [flash_seq_pkg::ADDR_W-1:0] CODE_ADDR,
   output logic                             CODE_GRANT,
   output logic                             FETCH_STALL,
   output logic                             EXTERNAL_DATA_RAM_WR,
   output logic                             EXTERNAL_DATA_RAM_RD,
   output logic [flash_seq_pkg::ADDR_W-1:0] EXTERNAL_DATA_RAM_ADDR,
   output logic [7:0]                       EXTERNAL_DATA_RAM_WDATA,
   input  wire flash_seq_pkg::dbg_req_type  DBG_REQ,
   output logic                             DBG_ACK,
   output logic                             DBG_REFUSED,
   output flash_seq_pkg::flash_req_type     FLASH_REQ,
   input  wire logic                        FLASH_DONE,
   input  wire logic [7:0]                  LOCK_BYTE,
   input  wire logic                        FLASH_ERR_CAUSE,
   output logic                             FLASH_ERROR_RESET
);
   import flash_seq_pkg::*;

   state_type s;       // registered state
   state_type next_s;  // next state

   // decides whether an access is forbidden by the lock settings
   function automatic logic denied(
      input logic              from_dbg,
      input op_kind_type       kind,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] exec,
      input logic [7:0]        pages
   );
      logic              any_lock;
      logic              tgt_lock;
      logic              exec_lock;
      logic [PAGE_W-1:0] tp;
      logic [PAGE_W-1:0] ep;
      any_lock  = pages != NO_PAGES_LOCKED;
      tp        = addr[ADDR_W-1:PAGE_LSB];
      ep        = exec[ADDR_W-1:PAGE_LSB];
      // pages below the count, plus the lock page once anything is locked
      tgt_lock  = ({2'h0, tp} < pages) || (any_lock && tp == LOCK_PAGE);
      exec_lock = ({2'h0, ep} < pages) || (any_lock && ep == LOCK_PAGE);
      if (kind == OP_FULL_ERASE)
         denied = !from_dbg;
      else if (addr >= RESERVED_BASE)
         denied = 1'b1;
      else if (kind == OP_ERASE && tp == LOCK_PAGE)
         denied = !from_dbg || any_lock;
      else if (kind == OP_WRITE && addr == LOCK_BYTE_ADDR && any_lock)
         denied = 1'b1;
      else if (tgt_lock)
         denied = from_dbg || !exec_lock;
      else
         denied = 1'b0;
   endfunction

   // next-state logic
   always_comb
   begin
      logic        bus_take;
      logic        bus_done;
      logic [1:0]  idx;
      op_kind_type mk;
      next_s             = s;
      bus_take           = (AVS_READ || AVS_WRITE) && s.waitreq;
      bus_done           = AVS_WRITE && !s.waitreq;
      idx                = MOVE_ADDR[1:0];
      mk                 = s.erase_en ? OP_ERASE : OP_WRITE;
      // one-cycle pulses fall back
      next_s.flash.start = 1'b0;
      next_s.external_data_ram_wr     = 1'b0;
      next_s.external_data_ram_rd     = 1'b0;
      next_s.code_grant  = 1'b0;
      next_s.err_reset   = 1'b0;
      next_s.dbg_ack     = 1'b0;
      next_s.dbg_refused = 1'b0;
      // waitrequest drops for one cycle after each taken request
      next_s.waitreq     = !bus_take;

      // lock count and error cause are caught once after reset release
      if (!s.captured)
      begin
         next_s.captured  = 1'b1;
         next_s.pages     = ~LOCK_BYTE;
         next_s.flash_err = FLASH_ERR_CAUSE;
      end

      // the array reports the end of the timed operation
      if (s.busy && FLASH_DONE)
         next_s.busy = 1'b0;

      // register writes land at the edge that sees waitrequest low
      if (bus_done && AVS_BYTEENABLE[0])
      begin
         unique case (AVS_ADDRESS)
            REG_STORE_CTRL:
            begin
               next_s.write_en = AVS_WRITEDATA[BIT_WRITE_EN];
               next_s.erase_en = AVS_WRITEDATA[BIT_ERASE_EN];
            end
            REG_CACHE_CTRL:
            begin
               next_s.block_sel = AVS_WRITEDATA[BIT_BLOCK_SEL];
               next_s.blk_next  = 2'h0;
            end
            REG_KEY:
            begin
               // keys must come in order; any slip disables until reset
               unique case (s.key)
                  KEY_LOCKED: next_s.key = (AVS_WRITEDATA[7:0] == KEY_FIRST_CODE) ? KEY_HALF : KEY_DEAD;
                  KEY_HALF:   next_s.key = (AVS_WRITEDATA[7:0] == KEY_SECOND_CODE) ? KEY_OPEN : KEY_DEAD;
                  KEY_OPEN:   next_s.key = KEY_DEAD;
                  KEY_DEAD:   next_s.key = KEY_DEAD;
               endcase
            end
            REG_SUPPLY:
            begin
               next_s.mon_en  = AVS_WRITEDATA[BIT_MON_EN];
               next_s.mon_rst = AVS_WRITEDATA[BIT_MON_RST];
            end
            default: ;                                                     // status and unmapped words ignore writes
         endcase
      end

      // register reads, unmapped words read zero
      if (bus_take && AVS_READ)
      begin
         next_s.readdata = READ_ZERO;
         unique case (AVS_ADDRESS)
            REG_STORE_CTRL:
            begin
               next_s.readdata[BIT_WRITE_EN] = s.write_en;
               next_s.readdata[BIT_ERASE_EN] = s.erase_en;
            end
            REG_CACHE_CTRL: next_s.readdata[BIT_BLOCK_SEL] = s.block_sel;
            REG_KEY:        next_s.readdata[1:0] = s.key;
            REG_STATUS:
            begin
               next_s.readdata[ST_BUSY]                 = s.busy;
               next_s.readdata[ST_FLASH_ERR]            = s.flash_err;
               next_s.readdata[ST_ANY_LOCK]             = s.pages != NO_PAGES_LOCKED;
               next_s.readdata[ST_PAGES_LSB+7:ST_PAGES_LSB] = s.pages;
            end
            REG_SUPPLY:
            begin
               next_s.readdata[BIT_MON_EN]  = s.mon_en;
               next_s.readdata[BIT_MON_RST] = s.mon_rst;
            end
            default: next_s.readdata = READ_ZERO;                          // unmapped words
         endcase
      end

      // move-reads never reach the store
      if (MOVE_RD)
      begin
         next_s.external_data_ram_rd   = 1'b1;
         next_s.external_data_ram_addr = MOVE_ADDR;
      end

      // move-writes: data RAM or store depending on write enable
      if (MOVE_WR)
      begin
         if (!s.write_en)
         begin
            next_s.external_data_ram_wr    = 1'b1;
            next_s.external_data_ram_addr  = MOVE_ADDR;
            next_s.external_data_ram_wdata = MOVE_DATA;
         end
         else if (!(s.mon_en && s.mon_rst))
            next_s.err_reset = 1'b1;
         else if (s.busy || !s.captured)
         begin
            // core is stalled while busy; nothing new is taken
         end
         else if (s.key != KEY_OPEN)
            next_s.key = KEY_DEAD;
         else
         begin
            next_s.key = KEY_LOCKED;
            if (denied(1'b0, mk, MOVE_ADDR, EXEC_ADDR, s.pages))
               next_s.err_reset = 1'b1;
            else if (s.erase_en)
            begin
               // erase needs both enables
               next_s.flash.start = 1'b1;
               next_s.flash.kind  = OP_ERASE;
               next_s.flash.addr  = MOVE_ADDR;
               next_s.flash.wdata = {4{MOVE_DATA}};
               next_s.flash.mask  = MASK_ALL_BYTES;
               next_s.busy        = 1'b1;
            end
            else if (!s.block_sel)
            begin
               // byte mode programs straight away
               next_s.flash.start = 1'b1;
               next_s.flash.kind  = OP_WRITE;
               next_s.flash.addr  = MOVE_ADDR;
               next_s.flash.wdata = {4{MOVE_DATA}};
               next_s.flash.mask  = MASK_ONE_BYTE << idx;
               next_s.busy        = 1'b1;
            end
            else if (idx == 2'h0)
            begin
               // first byte of an aligned block opens collection
               next_s.blk_addr      = MOVE_ADDR;
               next_s.blk_data[7:0] = MOVE_DATA;
               next_s.blk_next      = 2'h1;
            end
            else if (idx == s.blk_next && MOVE_ADDR[ADDR_W-1:2] == s.blk_addr[ADDR_W-1:2])
            begin
               next_s.blk_data[idx*8+:8] = MOVE_DATA;
               next_s.blk_next           = idx + 2'h1;
               if (idx == BLOCK_LAST_IDX)
               begin
                  // the last byte starts the four-byte program
                  next_s.flash.start = 1'b1;
                  next_s.flash.kind  = OP_WRITE;
                  next_s.flash.addr  = {s.blk_addr[ADDR_W-1:2], 2'h0};
                  next_s.flash.wdata = s.blk_data;
                  next_s.flash.wdata[31:24] = MOVE_DATA;
                  next_s.flash.mask  = MASK_ALL_BYTES;
                  next_s.busy        = 1'b1;
                  next_s.blk_next    = 2'h0;
               end
            end
            else
            begin
               // order broken: the partial block is dropped
               next_s.blk_next = 2'h0;
            end
         end
      end

      // code reads are checked and held off while busy; none is taken in the cycle after a grant or fault
      if (CODE_RD && s.captured && !s.busy && !s.code_grant && !s.err_reset)
      begin
         if (denied(1'b0, OP_READ, CODE_ADDR, EXEC_ADDR, s.pages))
            next_s.err_reset = 1'b1;
         else
            next_s.code_grant = 1'b1;
      end

      // debug requests: refused ones are only flagged, never reset
      if (DBG_REQ.valid && s.captured && !s.busy && !s.dbg_ack && !MOVE_WR)
      begin
         next_s.dbg_ack = 1'b1;
         if (denied(1'b1, DBG_REQ.kind, DBG_REQ.addr, EXEC_ADDR, s.pages))
            next_s.dbg_refused = 1'b1;
         else if (DBG_REQ.kind != OP_READ)
         begin
            next_s.flash.start = 1'b1;
            next_s.flash.kind  = DBG_REQ.kind;
            next_s.flash.addr  = DBG_REQ.addr;
            next_s.flash.wdata = {4{DBG_REQ.data}};
            next_s.flash.mask  = (DBG_REQ.kind == OP_WRITE) ? (MASK_ONE_BYTE << DBG_REQ.addr[1:0]) : MASK_ALL_BYTES;
            next_s.busy        = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         s         <= '0;
         s.key     <= KEY_LOCKED;
         s.waitreq <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign AVS_READDATA      = s.readdata;
   assign AVS_WAITREQUEST   = s.waitreq;
   assign CODE_GRANT        = s.code_grant;
   assign FETCH_STALL       = s.busy;
   assign EXTERNAL_DATA_RAM_WR           = s.external_data_ram_wr;
   assign EXTERNAL_DATA_RAM_RD           = s.external_data_ram_rd;
   assign EXTERNAL_DATA_RAM_ADDR         = s.external_data_ram_addr;
   assign EXTERNAL_DATA_RAM_WDATA        = s.external_data_ram_wdata;
   assign DBG_ACK           = s.dbg_ack;
   assign DBG_REFUSED       = s.dbg_refused;
   assign FLASH_REQ         = s.flash;
   assign FLASH_ERROR_RESET = s.err_reset;
endmodule

`default_nettype wire

// >>> verif/flash_array_model.sv
// behavioural flash array that answers each request after a program or erase time
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
#(
   parameter int WRITE_CYCLES = 3, // prompt program time
   parameter int ERASE_CYCLES = 9  // slow erase time
)
(
   input  wire logic                         CORE_CLK,
   input  wire logic                         NRST,
   input  wire flash_seq_pkg::flash_req_type FLASH_REQ,
   output logic                              FLASH_DONE
);
   import flash_seq_pkg::*;
   int remain; // cycles left in the running operation
   // count the operation down and pulse done in the cycle after its last counted cycle
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         remain     <= 0;
         FLASH_DONE <= 1'b0;
      end
      else
      begin
         FLASH_DONE <= (remain == 1);
         if (FLASH_REQ.start)
            remain <= (FLASH_REQ.kind == OP_WRITE) ? WRITE_CYCLES : ERASE_CYCLES;
         else if (remain != 0)
            remain <= remain - 1;
      end
   end
endmodule
`default_nettype wire

// >>> verif/flash_seq_assertions.sv
// concurrent checks on the ports of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_seq_checker
(
   input wire logic                               CORE_CLK,
   input wire logic                               NRST,
   input wire logic                               AVS_READ,
   input wire logic                               AVS_WRITE,
   input wire logic                               AVS_WAITREQUEST,
   input wire logic                               MOVE_WR,
   input wire logic                               MOVE_RD,
   input wire logic [flash_seq_pkg::ADDR_W-1:0]   MOVE_ADDR,
   input wire logic                               CODE_RD,
   input wire logic                               CODE_GRANT,
   input wire logic                               FETCH_STALL,
   input wire logic                               EXTERNAL_DATA_RAM_RD,
   input wire logic [flash_seq_pkg::ADDR_W-1:0]   EXTERNAL_DATA_RAM_ADDR,
   input wire flash_seq_pkg::dbg_req_type         DBG_REQ,
   input wire logic                               DBG_ACK,
   input wire logic                               DBG_REFUSED,
   input wire flash_seq_pkg::flash_req_type       FLASH_REQ,
   input wire logic                               FLASH_DONE,
   input wire logic                               FLASH_ERROR_RESET
);
   import flash_seq_pkg::*;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   // an idle bus request is answered in the next cycle, for one cycle
   a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus request not answered in one cycle");
   a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   // a new operation starts only from idle and raises the stall
   a_start_idle: assert property (FLASH_REQ.start |-> FETCH_STALL && !$past(FETCH_STALL))
      else $error("flash start while busy or without stall");
   a_done_release: assert property (FETCH_STALL && FLASH_DONE |=> !FETCH_STALL)
      else $error("stall not released after done");
   a_start_cause: assert property (FLASH_REQ.start |-> $past(MOVE_WR) || $past(DBG_REQ.valid))
      else $error("flash start without a write request");
   // a single byte write enables only the lane of its address
   a_byte_mask: assert property (FLASH_REQ.start && $past(MOVE_WR) && FLASH_REQ.kind == OP_WRITE
      && FLASH_REQ.mask != MASK_ALL_BYTES |-> FLASH_REQ.mask == (MASK_ONE_BYTE << FLASH_REQ.addr[1:0]))
      else $error("byte write mask wrong");
   a_move_read: assert property (MOVE_RD && !FETCH_STALL |=> EXTERNAL_DATA_RAM_RD && EXTERNAL_DATA_RAM_ADDR == $past(MOVE_ADDR))
      else $error("move read not sent to data ram");
   a_refuse_quiet: assert property (DBG_REFUSED |-> DBG_ACK && !FLASH_ERROR_RESET && !FLASH_REQ.start)
      else $error("refused debug request had an effect");
   a_dbg_answer: assert property ($past(NRST) && DBG_REQ.valid && !DBG_ACK && !FETCH_STALL && !MOVE_WR
      |=> DBG_ACK)
      else $error("debug request not acknowledged");
   a_code_grant: assert property (CODE_GRANT |-> $past(CODE_RD))
      else $error("code grant without request");
   c_start: cover property (FLASH_REQ.start && FLASH_REQ.mask == MASK_ALL_BYTES);
   c_refused: cover property (DBG_REFUSED);
   c_err: cover property (FLASH_ERROR_RESET);
endmodule
bind flash_write_security_ctrl flash_seq_checker flash_seq_checker_i (.*);
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the flash write and security sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb;
   import flash_seq_pkg::*;
   logic CORE_CLK = 1'b0, NRST = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [2:0] AVS_ADDRESS = 3'h0;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
   logic [3:0] AVS_BYTEENABLE = 4'h1; // only lane 0 carries writable fields
   logic AVS_WAITREQUEST, MOVE_WR = 1'b0, MOVE_RD = 1'b0, CODE_RD = 1'b0, CODE_GRANT, FETCH_STALL;
   logic [15:0] MOVE_ADDR = 16'h0, EXEC_ADDR = 16'h0, CODE_ADDR = 16'h0, EXTERNAL_DATA_RAM_ADDR;
   logic [7:0] MOVE_DATA = 8'h0, EXTERNAL_DATA_RAM_WDATA, LOCK_BYTE = 8'hFF;
   logic EXTERNAL_DATA_RAM_WR, EXTERNAL_DATA_RAM_RD, DBG_ACK, DBG_REFUSED, FLASH_DONE, FLASH_ERR_CAUSE = 1'b0, FLASH_ERROR_RESET;
   dbg_req_type DBG_REQ = '0;
   flash_req_type FLASH_REQ, last_req;
   logic [31:0] rq;                                   // read data of the last bus cycle
   logic [1:0] ooo [3] = '{2'h0, 2'h2, 2'h3};         // block bytes out of order
   int fail_count = 0, tests_run = 0;
   int n_start = 0, n_err = 0, n_xwr = 0, n_xrd = 0, n_grant = 0, s_start = 0, s_err = 0;
   flash_write_security_ctrl flash_write_security_ctrl_i (.*);
   flash_array_model flash_array_model_i (.*);
   always #50 CORE_CLK = ~CORE_CLK;
   // count the events the block produces
   always @(posedge CORE_CLK)
   begin
      n_start += (FLASH_REQ.start === 1'b1);
      n_err   += (FLASH_ERROR_RESET === 1'b1);
      n_xwr   += (EXTERNAL_DATA_RAM_WR === 1'b1);
      n_xrd   += (EXTERNAL_DATA_RAM_RD === 1'b1);
      n_grant += (CODE_GRANT === 1'b1);
      if (FLASH_REQ.start === 1'b1)
         last_req = FLASH_REQ;
   end
   // one register cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge CORE_CLK);
      AVS_ADDRESS   <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE     <= wr;
      AVS_READ      <= !wr;
      do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ  <= 1'b0;
   endtask
   task automatic st(input logic [2:0] a, input logic [15:0] e);
      bus(1'b0, a, 32'h0, rq);
      `CHK("register read", e, rq[15:0])
   endtask
   // one cpu move pulse, then wait until the store is idle
   task automatic mv(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [15:0] x);
      @(posedge CORE_CLK);
      MOVE_WR   <= wr;
      MOVE_RD   <= !wr;
      MOVE_ADDR <= a;
      MOVE_DATA <= d;
      EXEC_ADDR <= x;
      @(posedge CORE_CLK);
      MOVE_WR <= 1'b0;
      MOVE_RD <= 1'b0;
      do @(posedge CORE_CLK); while (FETCH_STALL !== 1'b0);
      @(posedge CORE_CLK);
   endtask
   // firmware byte write: keys, control bits, move, control cleared
   task automatic fw(input logic [15:0] a, input logic [7:0] d, input logic [15:0] x, input logic [1:0] c);
      bus(1'b1, REG_KEY, {24'h0, KEY_FIRST_CODE}, rq);
      bus(1'b1, REG_KEY, {24'h0, KEY_SECOND_CODE}, rq);
      bus(1'b1, REG_STORE_CTRL, {30'h0, c}, rq);
      mv(1'b1, a, d, x);
      bus(1'b1, REG_STORE_CTRL, 32'h0, rq);
   endtask
   task automatic ev(input int s, input int e);
      `CHK("flash starts", s, n_start - s_start)
      `CHK("error resets", e, n_err - s_err)
      s_start = n_start;
      s_err   = n_err;
   endtask
   // debug request held until acknowledged
   task automatic dbg(input op_kind_type k, input logic [15:0] a, input logic r);
      @(posedge CORE_CLK);
      DBG_REQ <= '{1'b1, k, a, 8'h3C};
      do @(posedge CORE_CLK); while (DBG_ACK !== 1'b1);
      `CHK("debug refused", r, DBG_REFUSED)
      DBG_REQ.valid <= 1'b0;
      do @(posedge CORE_CLK); while (FETCH_STALL !== 1'b0);
   endtask
   // code read held until granted or faulted
   task automatic code(input logic [15:0] a, input logic [15:0] x, input int g, input int e);
      int g0 = n_grant;
      @(posedge CORE_CLK);
      CODE_RD   <= 1'b1;
      CODE_ADDR <= a;
      EXEC_ADDR <= x;
      do @(posedge CORE_CLK); while (CODE_GRANT !== 1'b1 && FLASH_ERROR_RESET !== 1'b1);
      CODE_RD <= 1'b0;
      @(posedge CORE_CLK);
      `CHK("code grants", g, n_grant - g0)
      ev(0, e);
   endtask
   task automatic do_reset(input logic [7:0] lb, input logic cause);
      NRST            <= 1'b0;
      LOCK_BYTE       <= lb;
      FLASH_ERR_CAUSE <= cause;
      repeat (10) @(posedge CORE_CLK);
      NRST <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      FLASH_ERR_CAUSE <= 1'b0;
   endtask
   task automatic test_done();
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // run length is several hundred cycles; this cuts a hang at 30000 cycles
   initial
   begin
      #3_000_000;
      fail_count++;
      test_done();
   end
   initial
   begin
      do_reset(8'hFF, 1'b0);
      st(REG_STATUS, 16'h0000);
      st(3'h7, 16'h0000);
      mv(1'b0, 16'h0123, 8'h00, 16'h0000);
      `CHK("external_data_ram reads", 1, n_xrd)
      mv(1'b1, 16'h0124, 8'h77, 16'h0000);
      `CHK("external_data_ram writes", 1, n_xwr)
      `CHK("external_data_ram data", 8'h77, EXTERNAL_DATA_RAM_WDATA)
      bus(1'b1, REG_SUPPLY, 32'h3, rq);
      fw(16'h1002, 8'h5A, 16'h0000, 2'h1);
      ev(1, 0);
      `CHK("byte mask", 4'h4, last_req.mask)
      `CHK("byte data", 32'h5A5A5A5A, last_req.wdata)
      st(REG_KEY, 16'h0000);
      bus(1'b1, REG_CACHE_CTRL, 32'h1, rq);
      for (int i = 0; i < 4; i++)
      begin
         fw({14'h0800, i[1:0]}, (i == 2) ? 8'hFF : {6'h04, i[1:0]}, 16'h0000, 2'h1);
         ev(i == 3, 0);
      end
      `CHK("block mask", MASK_ALL_BYTES, last_req.mask)
      `CHK("block data", 32'h13FF1110, last_req.wdata)
      `CHK("block addr", 16'h2000, last_req.addr)
      foreach (ooo[j])
         fw({14'h0C00, ooo[j]}, 8'h00, 16'h0000, 2'h1);
      ev(0, 0);
      bus(1'b1, REG_CACHE_CTRL, 32'h0, rq);
      fw(16'h0800, 8'h00, 16'h0000, 2'h3);
      ev(1, 0);
      `CHK("erase kind", OP_ERASE, last_req.kind)
      dbg(OP_WRITE, 16'h7A00, 1'b0);
      dbg(OP_ERASE, 16'h7800, 1'b0);
      ev(2, 0);
      dbg(OP_WRITE, 16'h7C00, 1'b1);
      ev(0, 0);
      fw(16'h7BFF, 8'hFD, 16'h0000, 2'h1);
      ev(1, 0);
      st(REG_STATUS, 16'h0000);
      fw(16'h7C10, 8'h00, 16'h0000, 2'h1);
      ev(0, 1);
      do_reset(8'hFF, 1'b0);
      fw(16'h7800, 8'h00, 16'h0000, 2'h3);
      ev(0, 1);
      do_reset(8'hFF, 1'b1);
      st(REG_STATUS, 16'h0002);
      bus(1'b1, REG_SUPPLY, 32'h3, rq);
      fw(16'h7800, 8'h00, 16'h0000, 2'h3);
      ev(0, 1);
      do_reset(8'hFF, 1'b0);
      bus(1'b1, REG_SUPPLY, 32'h3, rq);
      bus(1'b1, REG_STORE_CTRL, 32'h1, rq);
      mv(1'b1, 16'h1000, 8'h00, 16'h0000);
      ev(0, 0);
      st(REG_KEY, 16'h0003);
      do_reset(8'hFD, 1'b0);
      st(REG_STATUS, 16'h0204);
      LOCK_BYTE <= 8'hFF;
      st(REG_STATUS, 16'h0204);
      dbg(OP_WRITE, 16'h0400, 1'b1);
      dbg(OP_READ, 16'h0000, 1'b1);
      dbg(OP_WRITE, 16'h7BFF, 1'b1);
      dbg(OP_ERASE, 16'h7800, 1'b1);
      ev(0, 0);
      dbg(OP_WRITE, 16'h0800, 1'b0);
      ev(1, 0);
      code(16'h2000, 16'h1000, 1, 0);
      code(16'h0000, 16'h0000, 1, 0);
      code(16'h7BFF, 16'h1000, 0, 1);
      do_reset(8'hFD, 1'b0);
      bus(1'b1, REG_SUPPLY, 32'h3, rq);
      fw(16'h0005, 8'h00, 16'h0100, 2'h1);
      ev(1, 0);
      fw(16'h0006, 8'h00, 16'h1000, 2'h1);
      ev(0, 1);
      do_reset(8'hFD, 1'b0);
      dbg(OP_FULL_ERASE, 16'h0000, 1'b0);
      ev(1, 0);
      `CHK("full erase kind", OP_FULL_ERASE, last_req.kind)
      test_done();
   end
endmodule
`default_nettype wire
